/* include/sscl_pkg.sv */
/*
 * sensor supply current-limit controller, channel A: register map, field
 * positions, reset values and cycle counts.
 * assumes a 250 MHz core clock; register access is the device's own
 * serial register port, seen here as a simple write/read strobe pair.
 */
// Functional notes
// RULE_01: retry field selects latchoff, 400ms, 4s, 12s
// RULE_02: host times restarts itself under latchoff
// RULE_03: blank field selects 5.5, 16.5, 55, 165ms
// RULE_04: dynamic blanking shortens only below power-good
// RULE_05: half blanking between 9V and 17V
// RULE_06: quarter blanking below 9V
// RULE_07: double limit above 18V when enabled
// RULE_08: limit disable stops sense amplifier and limiting
// RULE_09: supply enable turns on switch gate drive
// RULE_10: enable clear resets retry, latchoff, blanking timers
// RULE_11: enable pulses under 200us are ignored
// RULE_12: host keeps enable low to cool switch
// RULE_13: sustained overcurrent switches off, then retry or latch
// RULE_14: config fields read/write, zero at reset
package sscl_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] SSCL_CFG_A_OFFSET = 8'h18;
    localparam logic [7:0] SSCL_CFG_A_RESET = 8'h00;

    localparam int SSCL_ENABLE_BIT = 0;
    localparam int SSCL_LIMIT_DIS_BIT = 1;
    localparam int SSCL_DOUBLE_BIT = 2;
    localparam int SSCL_BLANK_LSB = 3;
    localparam int SSCL_DYN_BIT = 5;
    localparam int SSCL_RETRY_LSB = 6;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam longint SSCL_CLK_HZ = 250_000_000;
    localparam longint SSCL_FILTER_NS = 200_000;
    localparam longint SSCL_BLANK0_US = 5_500;
    localparam longint SSCL_BLANK1_US = 16_500;
    localparam longint SSCL_BLANK2_US = 55_000;
    localparam longint SSCL_BLANK3_US = 165_000;
    localparam longint SSCL_RETRY1_MS = 400;
    localparam longint SSCL_RETRY2_MS = 4_000;
    localparam longint SSCL_RETRY3_MS = 12_000;

    localparam longint SSCL_FILTER_CYC = SSCL_FILTER_NS * SSCL_CLK_HZ / 1_000_000_000;
    localparam longint SSCL_BLANK0_CYC = SSCL_BLANK0_US * SSCL_CLK_HZ / 1_000_000;
    localparam longint SSCL_BLANK1_CYC = SSCL_BLANK1_US * SSCL_CLK_HZ / 1_000_000;
    localparam longint SSCL_BLANK2_CYC = SSCL_BLANK2_US * SSCL_CLK_HZ / 1_000_000;
    localparam longint SSCL_BLANK3_CYC = SSCL_BLANK3_US * SSCL_CLK_HZ / 1_000_000;
    localparam longint SSCL_RETRY1_CYC = SSCL_RETRY1_MS * SSCL_CLK_HZ / 1_000;
    localparam longint SSCL_RETRY2_CYC = SSCL_RETRY2_MS * SSCL_CLK_HZ / 1_000;
    localparam longint SSCL_RETRY3_CYC = SSCL_RETRY3_MS * SSCL_CLK_HZ / 1_000;

    localparam int SSCL_CNT_W = 32;

    typedef enum logic [1:0] {
        SSCL_RETRY_LATCH,
        SSCL_RETRY_400MS,
        SSCL_RETRY_4S,
        SSCL_RETRY_12S
    } sscl_retry_t;

    typedef enum {
        SSCL_ST_OFF,
        SSCL_ST_ON,
        SSCL_ST_RETRY,
        SSCL_ST_LATCHED
    } sscl_state_t;

endpackage

/* hw/sscl_enable_filter.sv */
/*
 * glitch filter for the supply enable level.
 * assumes the input is a register bit on the same clock.
 */
`timescale 1ns/1ns
module sscl_enable_filter #(
    parameter int unsigned FILTER_CYC = 50_000
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic raw_i,
    output logic filt_o
);
    import sscl_pkg::*;

    logic [sscl_pkg::SSCL_CNT_W-1:0] cnt_reg;
    logic filt_reg;

    // ****************************************************************
    // level must hold FILTER_CYC cycles before it is accepted
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
            filt_reg <= 1'b0;
        end else if (raw_i == filt_reg) begin
            cnt_reg <= '0;
        end else if (cnt_reg >= SSCL_CNT_W'(FILTER_CYC - 1)) begin
            cnt_reg <= '0;
            filt_reg <= raw_i; // see RULE_11
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign filt_o = filt_reg;
endmodule

/* hw/sscl_top.sv */
/*
 * channel A sensor supply switch controller: config register, enable
 * filter, blanking and autoretry timing, gate drive.
 * assumes comparator levels from the analog front end arrive
 * asynchronously; register strobes are on clk_i.
 */
`timescale 1ns/1ns
module sscl_top #(
    parameter int unsigned FILTER_CYC = 32'(sscl_pkg::SSCL_FILTER_CYC),
    parameter int unsigned BLANK0_CYC = 32'(sscl_pkg::SSCL_BLANK0_CYC),
    parameter int unsigned BLANK1_CYC = 32'(sscl_pkg::SSCL_BLANK1_CYC),
    parameter int unsigned BLANK2_CYC = 32'(sscl_pkg::SSCL_BLANK2_CYC),
    parameter int unsigned BLANK3_CYC = 32'(sscl_pkg::SSCL_BLANK3_CYC),
    parameter int unsigned RETRY1_CYC = 32'(sscl_pkg::SSCL_RETRY1_CYC),
    parameter int unsigned RETRY2_CYC = 32'(sscl_pkg::SSCL_RETRY2_CYC),
    parameter int unsigned RETRY3_CYC = 32'(sscl_pkg::SSCL_RETRY3_CYC)
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic overcurrent_i,
    input wire logic below_pgood_i,
    input wire logic below_9v_i,
    input wire logic above_18v_i,
    output logic switch_gate_drive_o,
    output logic sense_amp_en_o,
    output logic double_limit_o,
    output logic limit_shutdown_o
);
    import sscl_pkg::*;

    // ****************************************************************
    // configuration register
    // ****************************************************************
    logic [7:0] cfg_reg;
    logic [7:0] rdata_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_reg <= SSCL_CFG_A_RESET; // see RULE_14
        end else if (reg_wr_i && reg_addr_i == SSCL_CFG_A_OFFSET) begin
            cfg_reg <= reg_wdata_i; // see RULE_14
        end
    end

    // reads have no side effect; other addresses read zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd_i) begin
            if (reg_addr_i == SSCL_CFG_A_OFFSET) begin
                rdata_reg <= cfg_reg;
            end else begin
                rdata_reg <= 8'h00;
            end
        end
    end
    assign reg_rdata_o = rdata_reg;

    logic supply_enable;
    logic limit_disable;
    logic double_limit_en;
    logic dynamic_blank_en;
    logic [1:0] blank_time_sel;
    logic [1:0] retry_period_sel;
    assign supply_enable = cfg_reg[SSCL_ENABLE_BIT];
    assign limit_disable = cfg_reg[SSCL_LIMIT_DIS_BIT];
    assign double_limit_en = cfg_reg[SSCL_DOUBLE_BIT];
    assign dynamic_blank_en = cfg_reg[SSCL_DYN_BIT];
    assign blank_time_sel = cfg_reg[SSCL_BLANK_LSB +: 2];
    assign retry_period_sel = cfg_reg[SSCL_RETRY_LSB +: 2];

    // ****************************************************************
    // comparator synchronisers
    // ****************************************************************
    logic [3:0] cmp_meta_reg;
    logic [3:0] cmp_sync_reg;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmp_meta_reg <= 4'h0;
            cmp_sync_reg <= 4'h0;
        end else begin
            cmp_meta_reg <= {above_18v_i, below_9v_i, below_pgood_i, overcurrent_i};
            cmp_sync_reg <= cmp_meta_reg;
        end
    end
    logic oc_s;
    logic pgood_low_s;
    logic low_9v_s;
    logic high_18v_s;
    assign oc_s = cmp_sync_reg[0];
    assign pgood_low_s = cmp_sync_reg[1];
    assign low_9v_s = cmp_sync_reg[2];
    assign high_18v_s = cmp_sync_reg[3];

    // ****************************************************************
    // enable filter
    // ****************************************************************
    logic enable_filt;
    sscl_enable_filter #(
        .FILTER_CYC(FILTER_CYC)
    ) u_filter (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .raw_i(supply_enable),
        .filt_o(enable_filt)
    );

    // ****************************************************************
    // effective blanking and retry periods
    // ****************************************************************
    logic [SSCL_CNT_W-1:0] blank_base;
    logic [SSCL_CNT_W-1:0] blank_eff;
    logic [SSCL_CNT_W-1:0] retry_len;
    always_comb begin
        case (blank_time_sel) // see RULE_03
            2'b00: blank_base = SSCL_CNT_W'(BLANK0_CYC);
            2'b01: blank_base = SSCL_CNT_W'(BLANK1_CYC);
            2'b10: blank_base = SSCL_CNT_W'(BLANK2_CYC);
            default: blank_base = SSCL_CNT_W'(BLANK3_CYC);
        endcase
        // shortening only below power-good, which keeps switch dissipation down
        if (dynamic_blank_en && pgood_low_s) begin // see RULE_04
            if (low_9v_s) begin
                blank_eff = blank_base >> 2; // see RULE_06
            end else begin
                blank_eff = blank_base >> 1; // see RULE_05
            end
        end else begin
            blank_eff = blank_base;
        end
        case (sscl_retry_t'(retry_period_sel)) // see RULE_01
            SSCL_RETRY_400MS: retry_len = SSCL_CNT_W'(RETRY1_CYC);
            SSCL_RETRY_4S: retry_len = SSCL_CNT_W'(RETRY2_CYC);
            SSCL_RETRY_12S: retry_len = SSCL_CNT_W'(RETRY3_CYC);
            default: retry_len = '0;
        endcase
    end

    // ****************************************************************
    // limit state machine
    // ****************************************************************
    sscl_state_t state_reg;
    logic [SSCL_CNT_W-1:0] blank_cnt_reg;
    logic [SSCL_CNT_W-1:0] retry_cnt_reg;
    logic limiting;
    assign limiting = oc_s && !limit_disable; // see RULE_08

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= SSCL_ST_OFF;
            blank_cnt_reg <= '0;
            retry_cnt_reg <= '0;
        end else if (!enable_filt) begin
            state_reg <= SSCL_ST_OFF; // see RULE_10
            blank_cnt_reg <= '0;
            retry_cnt_reg <= '0;
        end else begin
            case (state_reg)
                SSCL_ST_OFF: begin
                    state_reg <= SSCL_ST_ON; // see RULE_09
                end
                SSCL_ST_ON: begin
                    if (!limiting) begin
                        blank_cnt_reg <= '0;
                    end else if (blank_cnt_reg + 1'b1 >= blank_eff) begin
                        blank_cnt_reg <= '0;
                        retry_cnt_reg <= '0;
                        // latchoff leaves restart timing to the host
                        if (retry_period_sel == 2'b00) begin // see RULE_13
                            state_reg <= SSCL_ST_LATCHED;
                        end else begin
                            state_reg <= SSCL_ST_RETRY;
                        end
                    end else begin
                        blank_cnt_reg <= blank_cnt_reg + 1'b1;
                    end
                end
                SSCL_ST_RETRY: begin
                    if (retry_cnt_reg + 1'b1 >= retry_len) begin // see RULE_13
                        retry_cnt_reg <= '0;
                        state_reg <= SSCL_ST_ON;
                    end else begin
                        retry_cnt_reg <= retry_cnt_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= SSCL_ST_LATCHED;
                end
            endcase
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    logic gate_reg;
    logic amp_reg;
    logic dbl_reg;
    logic shut_reg;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            gate_reg <= 1'b0;
            amp_reg <= 1'b0;
            dbl_reg <= 1'b0;
            shut_reg <= 1'b0;
        end else begin
            gate_reg <= (state_reg == SSCL_ST_ON); // see RULE_09
            amp_reg <= !limit_disable; // see RULE_08
            dbl_reg <= double_limit_en && high_18v_s; // see RULE_07
            shut_reg <= (state_reg == SSCL_ST_RETRY) || (state_reg == SSCL_ST_LATCHED);
        end
    end
    assign switch_gate_drive_o = gate_reg;
    assign sense_amp_en_o = amp_reg;
    assign double_limit_o = dbl_reg;
    assign limit_shutdown_o = shut_reg;
endmodule

/* dv/sscl_switch_model.sv */
/* external switch and supply line model: load classes and voltage bands.
   assumes the bench sets load_i and level_i between clock edges. */
`timescale 1ns/1ns
module sscl_switch_model (
    input wire logic clk_i,
    input wire logic gate_i,
    input wire logic amp_en_i,
    input wire logic double_i,
    input wire logic [1:0] load_i,
    input wire logic [1:0] level_i,
    output logic overcurrent_o = 1'b0,
    output logic below_pgood_o = 1'b0,
    output logic below_9v_o = 1'b0,
    output logic above_18v_o = 1'b0
);
    // ********
    // load 1 sits between one and two limits, load 2 above both
    // ********
    always @(posedge clk_i) begin
        overcurrent_o <= gate_i && amp_en_i && (load_i == 2'h2 || (load_i == 2'h1 && !double_i));
        // switch off drags the line low, so every band reads low
        below_pgood_o <= !gate_i || level_i >= 2'h2;
        below_9v_o <= !gate_i || level_i == 2'h3;
        above_18v_o <= gate_i && level_i == 2'h0;
    end
endmodule

/* dv/sscl_top_props.sv */
/* port checker for sscl_top: register mirror, gate and limit relations.
   assumes it is bound to sscl_top and sees only its ports. */
`timescale 1ns/1ns
module sscl_checker #(
    parameter int unsigned FILTER_CYC = 20,
    parameter int unsigned RETRY1_CYC = 100
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic overcurrent_i,
    input wire logic above_18v_i,
    input wire logic switch_gate_drive_o,
    input wire logic sense_amp_en_o,
    input wire logic double_limit_o,
    input wire logic limit_shutdown_o
);
    import sscl_pkg::*;
    // ********
    // mirror and run lengths
    // ********
    logic [7:0] cfg_reg;
    logic [15:0] en_run_reg;
    logic [15:0] oc_run_reg;
    logic [15:0] shut_run_reg;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_reg <= SSCL_CFG_A_RESET;
        end else if (reg_wr_i && reg_addr_i == SSCL_CFG_A_OFFSET) begin
            cfg_reg <= reg_wdata_i;
        end
    end
    always_ff @(posedge clk_i) begin
        en_run_reg <= (rst_n_i && cfg_reg[SSCL_ENABLE_BIT]) ? en_run_reg + 16'h0001 : 16'h0000;
        oc_run_reg <= (rst_n_i && overcurrent_i) ? oc_run_reg + 16'h0001 : 16'h0000;
        shut_run_reg <= (rst_n_i && limit_shutdown_o) ? shut_run_reg + 16'h0001 : 16'h0000;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_RESET_QUIET: assert property ($rose(rst_n_i) |-> !switch_gate_drive_o)
        else $error("gate on right after reset");
    AST_READ_CFG: assert property (reg_rd_i && !reg_wr_i
        && reg_addr_i == SSCL_CFG_A_OFFSET
        |=> reg_rdata_o == $past(cfg_reg)) else $error("config read wrong");
    AST_READ_HOLE: assert property (reg_rd_i && reg_addr_i != SSCL_CFG_A_OFFSET
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    AST_SENSE_AMP: assert property ($stable(cfg_reg) [*4]
        |-> sense_amp_en_o == !cfg_reg[SSCL_LIMIT_DIS_BIT]) else $error("sense amp wrong");
    AST_DOUBLE: assert property ((cfg_reg[SSCL_DOUBLE_BIT] && above_18v_i) [*5]
        |-> double_limit_o) else $error("double limit missing");
    AST_GATE_RISE: assert property ($rose(switch_gate_drive_o)
        |-> cfg_reg[SSCL_ENABLE_BIT] && en_run_reg >= FILTER_CYC) else $error("early gate");
    AST_TRIP_CAUSE: assert property ($rose(limit_shutdown_o)
        |-> !cfg_reg[SSCL_LIMIT_DIS_BIT] && oc_run_reg >= 10) else $error("trip unjustified");
    AST_RELEASE: assert property ($fell(limit_shutdown_o) |-> !cfg_reg[SSCL_ENABLE_BIT]
        || (cfg_reg[SSCL_RETRY_LSB +: 2] != 2'b00 && shut_run_reg >= RETRY1_CYC - 2))
        else $error("early release");
    COV_TRIP: cover property ($rose(limit_shutdown_o));
    COV_RETRY: cover property ($fell(limit_shutdown_o) && cfg_reg[SSCL_ENABLE_BIT]);
    COV_DOUBLE: cover property (double_limit_o && switch_gate_drive_o);
endmodule
bind sscl_top sscl_checker #(.FILTER_CYC(FILTER_CYC), .RETRY1_CYC(RETRY1_CYC)) i_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .overcurrent_i(overcurrent_i), .above_18v_i(above_18v_i),
    .switch_gate_drive_o(switch_gate_drive_o), .sense_amp_en_o(sense_amp_en_o),
    .double_limit_o(double_limit_o), .limit_shutdown_o(limit_shutdown_o));

/* dv/sscl_top_tb_top.sv */
/* bench for sscl_top: registers, enable filter, blanking, retry, limits.
   assumes the switch model drives the comparator inputs. */
`timescale 1ns/1ns
module sscl_top_tb_top;
    import sscl_pkg::*;
    // ********
    // stimulus and checks
    // ********
    localparam int FLT = 20;
    localparam int BLK [4] = '{40, 80, 160, 320};
    localparam int RET [4] = '{0, 100, 200, 300};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] load = 2'h0;
    logic [1:0] lvl = 2'h0;
    logic [7:0] rdata, rv, cfg;
    logic oc, pg, b9, a18, gate, amp, dbl, shut, hi;
    logic [1:0] rt, bl, ld, lv;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int n, eff, sh;
    always #2 clk = ~clk;
    sscl_top #(.FILTER_CYC(FLT), .BLANK0_CYC(BLK[0]), .BLANK1_CYC(BLK[1]),
        .BLANK2_CYC(BLK[2]), .BLANK3_CYC(BLK[3]), .RETRY1_CYC(RET[1]),
        .RETRY2_CYC(RET[2]), .RETRY3_CYC(RET[3])) i_dut (
        .clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .overcurrent_i(oc), .below_pgood_i(pg),
        .below_9v_i(b9), .above_18v_i(a18), .switch_gate_drive_o(gate),
        .sense_amp_en_o(amp), .double_limit_o(dbl), .limit_shutdown_o(shut));
    sscl_switch_model i_sw (.clk_i(clk), .gate_i(gate), .amp_en_i(amp), .double_i(dbl),
        .load_i(load), .level_i(lvl), .overcurrent_o(oc), .below_pgood_o(pg),
        .below_9v_o(b9), .above_18v_o(a18));
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic close_out();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // strobes start a cycle after entry, so back-to-back calls never collide
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        rv = rdata;
    endtask
    // 0 gate on, 1 trip, 2 trip over, 3 all off
    task automatic wait_for(input int w, input int lim);
        n = 0;
        while (n < lim && ((w == 0 && gate !== 1'b1) || (w == 1 && shut !== 1'b1)
            || (w == 2 && shut !== 1'b0) || (w == 3 && (gate | shut) !== 1'b0))) begin
            @(negedge clk);
            n++;
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        void'($urandom(46789));
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        rd_reg(SSCL_CFG_A_OFFSET);
        check(rv === SSCL_CFG_A_RESET, "config reset value");
        cfg = 8'($urandom) & 8'hFE;
        wr_reg(SSCL_CFG_A_OFFSET, cfg);
        wr_reg(8'h19, 8'hFF);
        rd_reg(8'h19);
        check(rv === 8'h00, "unmapped read");
        repeat (2) begin
            rd_reg(SSCL_CFG_A_OFFSET);
            check(rv === cfg, "config readback");
        end
        wr_reg(SSCL_CFG_A_OFFSET, 8'h01);
        repeat (8) @(negedge clk);
        wr_reg(SSCL_CFG_A_OFFSET, 8'h00);
        hi = 1'b0;
        repeat (40) begin
            @(negedge clk);
            hi = hi | gate;
        end
        check(hi === 1'b0, "short enable passed");
        for (int i = 0; i < 12; i++) begin
            bl = (i < 4) ? 2'(i) : 2'($urandom);
            rt = (i < 4) ? 2'(3 - i) : 2'($urandom);
            // first passes walk every band and always trip; pass 4 holds the double limit
            lv = (i < 4) ? 2'(i) : ((i == 4) ? 2'h0 : 2'($urandom));
            ld = (i < 4) ? 2'h2 : ((i == 4) ? 2'h1 : 2'($urandom_range(2, 1)));
            cfg = {rt, (i == 2 || i == 3) | 1'($urandom), bl, (i == 4) | 1'($urandom), 2'b01};
            lvl = lv;
            wr_reg(SSCL_CFG_A_OFFSET, cfg);
            wait_for(0, 60);
            check(n >= FLT - 2 && n <= FLT + 6, "enable delay");
            repeat (6) @(negedge clk);
            load = ld;
            sh = (cfg[5] && lv >= 2) ? ((lv == 3) ? 2 : 1) : 0;
            eff = BLK[bl] >> sh;
            wait_for(1, 400);
            load = 2'h0;
            if (ld == 1 && cfg[2] && lv == 0) begin
                check(shut === 1'b0 && dbl === 1'b1 && amp === 1'b1, "double limit");
            end else begin
                check(n >= eff && n <= eff + 8 && gate === 1'b0, "blanking");
                wait_for(2, 400);
                @(negedge clk);
                if (rt == 0) check(n == 400 && gate === 1'b0, "latchoff");
                else check(n >= RET[rt] - 2 && n <= RET[rt] + 4 && gate === 1'b1, "retry");
            end
            // host clears enable and keeps it low so the switch cools
            wr_reg(SSCL_CFG_A_OFFSET, 8'h00);
            wait_for(3, FLT + 10);
            check((gate | shut) === 1'b0, "enable clear");
            repeat (30) @(negedge clk);
        end
        wr_reg(SSCL_CFG_A_OFFSET, 8'h03);
        wait_for(0, 60);
        load = 2'h2;
        repeat (300) @(negedge clk);
        check(shut === 1'b0 && gate === 1'b1 && amp === 1'b0, "limit disabled");
        load = 2'h0;
        close_out();
    end
endmodule
